//--- src/aeqec_pkg.sv
package aeqec_pkg;

	// Register map offsets
	localparam logic [7:0] ADDR_EQ_ADAPT_CTL   = 8'h42;
	localparam logic [7:0] ADDR_ERR_LIMIT      = 8'h43;
	localparam logic [7:0] ADDR_LINK_CAP       = 8'h4A;
	localparam logic [7:0] ADDR_PORT_SEL       = 8'h4C;

	// Reset values
	localparam logic [7:0] RST_EQ_ADAPT_CTL    = 8'h71;
	localparam logic [7:0] RST_ERR_LIMIT       = 8'h01;
	localparam logic [7:0] RST_LINK_CAP        = 8'h00;
	localparam logic [7:0] RST_PORT_SEL        = 8'h00;

	// Field positions
	localparam int CTL_SEL_HI                  = 6;
	localparam int CTL_SEL_LO                  = 4;
	localparam int CTL_TWO_PHASE               = 2;
	localparam int CTL_LOOP_ORDER              = 1;
	localparam int CTL_SF_EN                   = 0;
	localparam int CAP_CRC_FLAG                = 4;
	localparam int PSEL_READ_PORT              = 4;
	localparam logic [7:0] CTL_WR_MASK         = 8'h7F;
	localparam logic [7:0] PSEL_WR_MASK        = 8'h13;

	// Setting ranges
	localparam int NUM_PORTS                   = 2;
	localparam int SET_W                       = 4;
	localparam logic [SET_W-1:0] EQ_MAX        = 4'hF;
	localparam logic [SET_W-1:0] EQ_MIN        = 4'h0;
	localparam logic [SET_W-1:0] SF_LEGAL_MAX  = 4'hE;
	localparam int TMR_W                       = 16;
	localparam int ACC_W                       = 9;

	typedef struct packed {
		logic clk_err;
		logic enc_err;
		logic par_err;
	} aeqec_link_err_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} aeqec_reg_req_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETTLE,
		ST_COUNT,
		ST_MONITOR
	} aeqec_state_e;

endpackage

//--- src/aeqec_err_accum.sv
module aeqec_err_accum
	import aeqec_pkg::*;
(
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_arst_n,
	// Control
	input  wire logic             i_clear,
	input  wire logic             i_err,
	// Count
	output logic [ACC_W-1:0]      o_count
);

	logic [ACC_W-1:0] count_r;
	logic [ACC_W-1:0] count_nxt;
	wire              at_top = &count_r;

	// Saturates so a long noisy window never wraps back below the limit
	assign count_nxt = i_clear ? {ACC_W{1'b0}} :
	                   (i_err && !at_top) ? count_r + {{(ACC_W-1){1'b0}}, 1'b1} : count_r;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			count_r <= '0;
		else
			count_r <= count_nxt;
	end

	assign o_count = count_r;

endmodule // aeqec_err_accum

//--- src/aeqec_adapt_ctrl.sv
module aeqec_adapt_ctrl
	import aeqec_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_arst_n,
	// Register access
	input  wire aeqec_reg_req_s        i_reg,
	output logic [7:0]                 o_reg_rdata,
	// Adaptation control
	input  wire logic                  i_adapt_start,
	input  wire logic [TMR_W-1:0]      i_relock_wait_period,
	input  wire logic [SET_W-1:0]      i_sf_min,
	input  wire logic [SET_W-1:0]      i_sf_max,
	// Link status
	input  wire logic                  i_lock_async,
	input  wire aeqec_link_err_s       i_link_err,
	input  wire logic [NUM_PORTS-1:0]  i_crc_err,
	// Adaptation results
	output logic [SET_W-1:0]           o_eq_setting,
	output logic [SET_W-1:0]           o_sf_setting,
	output logic                       o_adapt_locked,
	output logic [ACC_W-1:0]           o_err_count,
	// CRC flagging
	output logic [NUM_PORTS-1:0]       o_encoder_crc_flag_en,
	output logic [NUM_PORTS-1:0]       o_crc_err_flag
);

	// Register file
	logic [7:0]           ctl_r;
	logic [7:0]           limit_r;
	logic [7:0]           psel_r;
	logic [7:0]           cap_r [NUM_PORTS];
	logic [7:0]           rdata_r;

	wire wr_ctl   = i_reg.wr && (i_reg.addr == ADDR_EQ_ADAPT_CTL);
	wire wr_limit = i_reg.wr && (i_reg.addr == ADDR_ERR_LIMIT);
	wire wr_psel  = i_reg.wr && (i_reg.addr == ADDR_PORT_SEL);
	wire wr_cap   = i_reg.wr && (i_reg.addr == ADDR_LINK_CAP);
	wire rd_port  = psel_r[PSEL_READ_PORT];

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctl_r   <= RST_EQ_ADAPT_CTL;
			limit_r <= RST_ERR_LIMIT;
			psel_r  <= RST_PORT_SEL;
		end else begin
			if (wr_ctl)
				ctl_r <= i_reg.wdata & CTL_WR_MASK;
			if (wr_limit)
				limit_r <= i_reg.wdata;
			if (wr_psel)
				psel_r <= i_reg.wdata & PSEL_WR_MASK;
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
			always_ff @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n)
					cap_r[gp] <= RST_LINK_CAP;
				else if (wr_cap && psel_r[gp])
					cap_r[gp] <= i_reg.wdata;
			end
			assign o_encoder_crc_flag_en[gp] = cap_r[gp][CAP_CRC_FLAG];
			// Flag only when the port's capability bit is set
			always_ff @(posedge i_clk or negedge i_arst_n) begin
				if (!i_arst_n)
					o_crc_err_flag[gp] <= 1'b0;
				else
					o_crc_err_flag[gp] <= i_crc_err[gp] & cap_r[gp][CAP_CRC_FLAG];
			end
		end
	endgenerate

	// Unmapped offsets read as zero; bit 6 of port select is always zero locally
	wire [7:0] rd_mux = (i_reg.addr == ADDR_EQ_ADAPT_CTL) ? ctl_r :
	                    (i_reg.addr == ADDR_ERR_LIMIT)    ? limit_r :
	                    (i_reg.addr == ADDR_PORT_SEL)     ? psel_r :
	                    (i_reg.addr == ADDR_LINK_CAP)     ? cap_r[rd_port] : 8'h00;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			rdata_r <= 8'h00;
		else if (i_reg.rd)
			rdata_r <= rd_mux;
	end
	assign o_reg_rdata = rdata_r;

	// Control fields
	wire [2:0] err_sel    = ctl_r[CTL_SEL_HI:CTL_SEL_LO];
	wire       two_phase  = ctl_r[CTL_TWO_PHASE];
	wire       loop_order = ctl_r[CTL_LOOP_ORDER];
	wire       sf_en      = ctl_r[CTL_SF_EN];

	// Selected error of this cycle
	wire err_hit = |(err_sel & {i_link_err.clk_err, i_link_err.enc_err, i_link_err.par_err});

	// Lock comes from the analog front end: three stages, accept when last two agree
	logic [2:0] lock_sync_r;
	logic       lock_r;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lock_sync_r <= 3'h0;
			lock_r      <= 1'b0;
		end else begin
			lock_sync_r <= {lock_sync_r[1:0], i_lock_async};
			if (lock_sync_r[1] == lock_sync_r[2])
				lock_r <= lock_sync_r[2];
		end
	end

	// Filter bounds, clipped to the legal range
	wire [SET_W-1:0] sf_hi = (i_sf_max > SF_LEGAL_MAX) ? SF_LEGAL_MAX : i_sf_max;
	wire [SET_W-1:0] sf_lo = (i_sf_min > sf_hi) ? sf_hi : i_sf_min;

	// Timer targets; half period never below one cycle
	wire [TMR_W-1:0] half_raw = {1'b0, i_relock_wait_period[TMR_W-1:1]};
	wire [TMR_W-1:0] half_per = (half_raw == '0) ? {{(TMR_W-1){1'b0}}, 1'b1} : half_raw;
	wire [TMR_W-1:0] full_per = (i_relock_wait_period == '0) ? {{(TMR_W-1){1'b0}}, 1'b1} :
	                            i_relock_wait_period;

	aeqec_state_e    state_r;
	aeqec_state_e    state_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [SET_W-1:0] eq_r;
	logic [SET_W-1:0] sf_r;
	logic [SET_W-1:0] eq_nxt;
	logic [SET_W-1:0] sf_nxt;
	logic             tmr_clr;
	logic             acc_clr;
	logic [ACC_W-1:0] acc_count;

	wire settle_end = (tmr_r + {{(TMR_W-1){1'b0}}, 1'b1}) >= (two_phase ? half_per : full_per);
	wire half_end   = (tmr_r + {{(TMR_W-1){1'b0}}, 1'b1}) >= half_per;
	wire over_limit = acc_count > {1'b0, limit_r};

	// Next candidate in the sweep
	wire eq_last = (eq_r == EQ_MAX);
	wire sf_last = (sf_r >= sf_hi);
	logic [SET_W-1:0] eq_step;
	logic [SET_W-1:0] sf_step;
	always_comb begin
		eq_step = eq_r;
		sf_step = sf_r;
		if (!sf_en) begin
			eq_step = eq_last ? EQ_MIN : eq_r + 4'h1;
			sf_step = sf_r;
		end else if (!loop_order) begin
			eq_step = eq_last ? EQ_MIN : eq_r + 4'h1;
			sf_step = eq_last ? (sf_last ? sf_lo : sf_r + 4'h1) : sf_r;
		end else begin
			sf_step = sf_last ? sf_lo : sf_r + 4'h1;
			eq_step = sf_last ? (eq_last ? EQ_MIN : eq_r + 4'h1) : eq_r;
		end
	end

	always_comb begin
		state_nxt = state_r;
		eq_nxt    = eq_r;
		sf_nxt    = sf_r;
		tmr_clr   = 1'b0;
		acc_clr   = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (i_adapt_start) begin
					state_nxt = ST_SETTLE;
					eq_nxt    = EQ_MIN;
					sf_nxt    = sf_lo;
					tmr_clr   = 1'b1;
				end
			end
			ST_SETTLE: begin
				if (settle_end) begin
					tmr_clr = 1'b1;
					acc_clr = 1'b1;
					if (two_phase)
						state_nxt = ST_COUNT;
					else if (lock_r)
						state_nxt = ST_MONITOR;
					else begin
						eq_nxt = eq_step;
						sf_nxt = sf_step;
					end
				end
			end
			ST_COUNT: begin
				if (err_hit) begin
					state_nxt = ST_SETTLE;
					eq_nxt    = eq_step;
					sf_nxt    = sf_step;
					tmr_clr   = 1'b1;
				end else if (half_end) begin
					tmr_clr = 1'b1;
					acc_clr = 1'b1;
					if (lock_r)
						state_nxt = ST_MONITOR;
					else begin
						state_nxt = ST_SETTLE;
						eq_nxt    = eq_step;
						sf_nxt    = sf_step;
					end
				end
			end
			ST_MONITOR: begin
				if (half_end) begin
					tmr_clr = 1'b1;
					acc_clr = 1'b1;
					if (over_limit && !eq_last) begin
						state_nxt = ST_SETTLE;
						eq_nxt    = eq_r + 4'h1;
					end
					// At the top setting the equalizer simply stays put
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		if (state_r != ST_IDLE && i_adapt_start) begin
			state_nxt = ST_SETTLE;
			eq_nxt    = EQ_MIN;
			sf_nxt    = sf_lo;
			tmr_clr   = 1'b1;
		end
		// Bounds may be reprogrammed mid-sweep
		if (sf_nxt > sf_hi)
			sf_nxt = sf_hi;
		if (sf_nxt < sf_lo)
			sf_nxt = sf_lo;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= ST_IDLE;
			tmr_r   <= '0;
			eq_r    <= EQ_MIN;
			sf_r    <= EQ_MIN;
		end else begin
			state_r <= state_nxt;
			tmr_r   <= tmr_clr ? '0 : tmr_r + {{(TMR_W-1){1'b0}}, 1'b1};
			eq_r    <= eq_nxt;
			sf_r    <= sf_nxt;
		end
	end

	aeqec_err_accum u_accum (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_clear  (acc_clr),
		.i_err    (err_hit),
		.o_count  (acc_count)
	);

	assign o_eq_setting   = eq_r;
	assign o_sf_setting   = sf_r;
	assign o_adapt_locked = (state_r == ST_MONITOR);
	assign o_err_count    = acc_count;

endmodule // aeqec_adapt_ctrl

//--- test/aeqec_monitor.sv
module aeqec_monitor
	import aeqec_pkg::*;
(
	// Clock and reset
	input wire logic                 i_clk,
	input wire logic                 i_arst_n,
	// Watched ports
	input wire aeqec_reg_req_s       i_reg,
	input wire logic [7:0]           o_reg_rdata,
	input wire logic                 i_adapt_start,
	input wire logic [NUM_PORTS-1:0] i_crc_err,
	input wire logic [SET_W-1:0]     o_eq_setting,
	input wire logic [SET_W-1:0]     o_sf_setting,
	input wire logic                 o_adapt_locked,
	input wire logic [ACC_W-1:0]     o_err_count,
	input wire logic [NUM_PORTS-1:0] o_encoder_crc_flag_en,
	input wire logic [NUM_PORTS-1:0] o_crc_err_flag
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking mon_cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_restart;
		i_adapt_start ##1 !o_adapt_locked;
	endsequence

	a_start_from_zero: assert property (s_restart |-> o_eq_setting == EQ_MIN ##1 !o_adapt_locked)
		else $error("sweep did not restart from the lowest setting");
	a_eq_hold_top: assert property (o_adapt_locked && o_eq_setting == EQ_MAX && !i_adapt_start |=> o_eq_setting == EQ_MAX)
		else $error("top equalizer setting not held");
	a_eq_step_one: assert property (o_adapt_locked && !i_adapt_start |=>
		o_eq_setting == $past(o_eq_setting) || o_eq_setting == $past(o_eq_setting) + 4'h1)
		else $error("equalizer moved by more than one step while locked");
	a_sf_legal_range: assert property (o_sf_setting <= SF_LEGAL_MAX)
		else $error("sample filter setting out of range");
	a_count_step: assert property (o_err_count == $past(o_err_count) || o_err_count == $past(o_err_count) + 9'h001
		|| o_err_count <= 9'h001)
		else $error("error count jumped");
	a_crc_flag_gate: assert property (o_crc_err_flag == ($past(i_crc_err) & $past(o_encoder_crc_flag_en)))
		else $error("crc flag does not follow gated error");
	a_cap_write_only: assert property (!i_reg.wr |=> $stable(o_encoder_crc_flag_en))
		else $error("capability changed without a write");
	a_rdata_hold: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
		else $error("read data changed without a read");
endmodule // aeqec_monitor

bind aeqec_adapt_ctrl aeqec_monitor aeqec_monitor_inst (.i_clk, .i_arst_n, .i_reg, .o_reg_rdata, .i_adapt_start,
	.i_crc_err, .o_eq_setting, .o_sf_setting, .o_adapt_locked, .o_err_count, .o_encoder_crc_flag_en, .o_crc_err_flag);

//--- test/aeqec_remote_ser.sv
module aeqec_remote_ser
	import aeqec_pkg::*;
(
	// Bench requests
	input  wire logic            i_link_up,
	input  wire aeqec_link_err_s i_err_req,
	// Link status towards the receiver
	output logic                 o_lock,
	output aeqec_link_err_s      o_err
);
	timeunit 1ns;
	timeprecision 100ps;
	initial o_lock = 1'b0;
	// Lock arrives off the receive clock grid so the synchroniser is exercised
	always @(i_link_up) o_lock <= #1.3 i_link_up;
	assign o_err = i_err_req;
endmodule // aeqec_remote_ser

//--- test/aeqec_adapt_ctrl_tb.sv
module aeqec_adapt_ctrl_tb
	import aeqec_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] a, d; logic w; logic [7:0] e;} aeqec_row_s;
	logic            clk = 0, arst_n = 0, start = 0, link_up = 0, lock, locked;
	logic [1:0]      crc = '0, fen, flag;
	aeqec_reg_req_s  req = '0;
	aeqec_link_err_s err_req = '0, err;
	logic [7:0]      rdata, v;
	logic [3:0]      eq, sf, sf_min = 4'h2, sf_max = 4'h3;
	logic [8:0]      cnt;
	int              n_fail = 0, n_compared = 0, cyc = 0, n;
	aeqec_row_s      rows[9] = '{'{8'h42, 8'h00, 0, 8'h71}, '{8'h43, 8'h00, 0, 8'h01}, '{8'h4A, 8'h00, 0, 8'h00},
		'{8'h4C, 8'h00, 0, 8'h00}, '{8'h45, 8'h00, 0, 8'h00}, '{8'h42, 8'hFF, 1, 8'h7F}, '{8'h43, 8'h05, 1, 8'h05},
		'{8'h4C, 8'hFF, 1, 8'h13}, '{8'h46, 8'hAA, 1, 8'h00}};

	aeqec_adapt_ctrl aeqec_adapt_ctrl_inst (.i_clk(clk), .i_arst_n(arst_n), .i_reg(req), .o_reg_rdata(rdata),
		.i_adapt_start(start), .i_relock_wait_period(16'h0008), .i_sf_min(sf_min), .i_sf_max(sf_max), .i_lock_async(lock),
		.i_link_err(err), .i_crc_err(crc), .o_eq_setting(eq), .o_sf_setting(sf), .o_adapt_locked(locked),
		.o_err_count(cnt), .o_encoder_crc_flag_en(fen), .o_crc_err_flag(flag));
	aeqec_remote_ser aeqec_remote_ser_inst (.i_link_up(link_up), .i_err_req(err_req), .o_lock(lock), .o_err(err));

	always #2 clk = ~clk;

	task automatic end_sim();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Long enough for every sweep below with a wide margin
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic check(string nm, logic [8:0] seen, logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk) req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) req <= '0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) req <= '0;
		@(posedge clk) v = rdata;
	endtask
	task automatic go(logic [7:0] ctl);
		wr(ADDR_EQ_ADAPT_CTL, ctl);
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
	endtask
	task automatic sweep(logic [7:0] ctl, int k, logic [3:0] xe, logic [3:0] xs);
		go(ctl);
		repeat (8 * k + 3) @(posedge clk);
		#1 check("eq", eq, xe);
		check("sf", sf, xs);
	endtask
	// Error lands in the first cycle of the counting half
	task automatic tp(logic [7:0] ctl, logic [2:0] e, logic [3:0] xe);
		go(ctl);
		repeat (4) @(posedge clk);
		err_req <= aeqec_link_err_s'(e);
		@(posedge clk) err_req <= '0;
		repeat (2) @(posedge clk);
		#1 check("eq2", eq, xe);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
			end
			rd(rows[i].a);
			check("reg", v, rows[i].e);
		end
		wr(ADDR_LINK_CAP, 8'h10);
		#1 check("fen", fen, 2'b11);
		wr(ADDR_PORT_SEL, 8'h01);
		wr(ADDR_LINK_CAP, 8'h00);
		rd(ADDR_LINK_CAP);
		check("cap0", v, 8'h00);
		check("fen", fen, 2'b10);
		wr(ADDR_PORT_SEL, 8'h10);
		rd(ADDR_LINK_CAP);
		check("cap1", v, 8'h10);
		// Encoder CRC taken as switched on elsewhere, so error pulses reach the port
		@(posedge clk) crc <= 2'b11;
		@(posedge clk) crc <= 2'b00;
		#1 check("flag", flag, 2'b10);
		sweep(8'h70, 3, 4'h3, 4'h2);
		sweep(8'h71, 16, 4'h0, 4'h3);
		sweep(8'h73, 1, 4'h0, 4'h3);
		sweep(8'h73, 2, 4'h1, 4'h2);
		// Maximum above the legal range must clip to 14
		@(posedge clk) sf_max <= 4'hF;
		sf_min <= 4'hD;
		sweep(8'h73, 1, 4'h0, 4'hE);
		sweep(8'h73, 2, 4'h1, 4'hD);
		link_up <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			tp(8'h04 | (8'h10 << k), 3'h1 << k, 4'h1);
			tp(8'h04 | (8'h10 << k), ~(3'h1 << k), 4'h0);
		end
		tp(8'h04, 3'h7, 4'h0);
		// Two-phase half plus half lands on the same cycle as the full wait
		for (int m = 0; m < 2; m++) begin
			go(m ? 8'h70 : 8'h74);
			n = 1;
			@(negedge clk);
			while (locked !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			check("settle", n, 9);
		end
		wr(ADDR_ERR_LIMIT, 8'h02);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk) err_req <= aeqec_link_err_s'({2'b00, i[0]});
		end
		#1 check("eq_lim", eq, 4'h0);
		for (int i = 0; i < 400; i++) begin
			@(posedge clk) err_req <= aeqec_link_err_s'(3'h1);
		end
		#1 check("eq_top", eq, 4'hF);
		check("acc", {8'h00, cnt <= 9'h004}, 9'h001);
		@(posedge clk) arst_n <= 1'b0;
		err_req <= '0;
		#1 check("rst_eq", eq, 4'h0);
		check("rst_lock", locked, 1'b0);
		@(posedge clk) arst_n <= 1'b1;
		rd(ADDR_ERR_LIMIT);
		check("rst_lim", v, 8'h01);
		end_sim();
	end
endmodule // aeqec_adapt_ctrl_tb
